// ===== verilog/txs_pkg.sv
// shared constants and types for the transmitter serial configuration block
// Notes on behaviour
// RULE1: unframed: host holds chip-on high, tx_on_n low
// RULE2: valid data out 7 us after tx_valid
// RULE3: single calibration: warm wake takes 110 us
// RULE4: rf power falls 3.5 to 13.5 after tx_valid; the code reaches at most 3.5 us plus 3 times 814 cycles, about 13.27 us
// RULE5: transmit bit sampled on the reference clock
// RULE6: serial words are 24 bits, msb first
// RULE7: strobe low shifts on clock; high ignores
// RULE8: strobe rise decodes address and loads word
// RULE9: host clocks exactly 24 bits per word
// RULE10: bit 23 selects frequency or configuration word
// RULE11: frequency word: integer 22:20, fraction 19:0
// RULE12: frequency word accepted in standby or operation
// RULE13: reset 22, write gate 21, address, data
// RULE14: host writes configuration only in standby
// RULE15: reset bit reloads all configuration defaults
// RULE16: host writes register 0 first
// RULE17: register 0 holds rate, ask, power saving
// RULE18: pll sleep select: pll off while tx_on_n high
// RULE19: single calibration limits calibration to reset
// RULE20: lock gate holds transmitter off while unlocked
// RULE21: off delay is 3.5 us plus field times 40
// RULE22: divider base is offset plus 147
// RULE23: mode decoded from chip-on, tx_on_n, ask, saving
// RULE24: tx_valid pair complementary, inhibited while unlocked
// RULE25: write gate at zero leaves registers unchanged; the code still reloads all defaults when reset bit 22 is set
package txs_pkg;
    localparam int WORD_W = 24;
    localparam int CFG_W = 16;
    localparam int NUM_CFG = 5;
    localparam int FREQ_W = 23;
    localparam int TYPE_BIT = 23;
    localparam int RESET_BIT = 22;
    localparam int WGATE_BIT = 21;
    localparam int ADDR_HI = 20;
    localparam int ADDR_LO = 16;
    localparam int INT_HI = 22;
    localparam int INT_LO = 20;
    localparam int FRAC_HI = 19;
    localparam logic [4:0] MODE_CONFIG_ADDR = 5'h00;
    localparam logic [4:0] FILTER_DIVIDER_CONFIG_ADDR = 5'h01;
    localparam logic [4:0] TX_TIMING_CONFIG_ADDR = 5'h02;
    localparam logic [4:0] RESERVED_CONFIG_THREE_ADDR = 5'h03;
    localparam logic [4:0] MODULATION_SCALE_CONFIG_ADDR = 5'h04;
    localparam logic [15:0] MODE_CONFIG_RST = 16'h263e;
    localparam logic [15:0] FILTER_DIVIDER_CONFIG_RST = 16'h8487;
    localparam logic [15:0] TX_TIMING_CONFIG_RST = 16'h158a;
    localparam logic [15:0] RESERVED_CONFIG_THREE_RST = 16'h5505;
    localparam logic [15:0] MODULATION_SCALE_CONFIG_RST = 16'h0080;
    localparam logic [22:0] FREQ_RST = 23'h000000;
    localparam int RATE_BIT = 14;
    localparam int ASK_BIT = 13;
    localparam int SAVE_BIT = 12;
    localparam int SLEEP_BIT = 11;
    localparam int ONECAL_BIT = 10;
    localparam int LOCKG_BIT = 9;
    localparam int DIVOFF_HI = 15;
    localparam int DIVOFF_LO = 12;
    localparam int FEDGE_BIT = 5;
    localparam int FPOL_BIT = 4;
    localparam int OFFD_HI = 7;
    localparam int OFFD_LO = 6;
    localparam int OND_HI = 5;
    localparam int OND_LO = 0;
    localparam int SCALE_HI = 15;
    localparam int SCALE_LO = 8;
    localparam int SOFF_HI = 7;
    localparam int SOFF_LO = 0;
    localparam logic [7:0] DIV_BASE_ADD = 8'h93;
    localparam int CLK_NS = 4;
    localparam int REF_PERIOD_PS = 81380;
    localparam int DATA_VALID_LAG_NS = 7000;
    localparam int DATA_VALID_LAG_CYC = DATA_VALID_LAG_NS / CLK_NS;
    localparam int WARM_WAKE_LAG_US = 110;
    localparam int COLD_WAKE_US = 250;
    localparam int LOWCUR_WAKE_US = 2000;
    localparam int RF_FALL_BASE_NS = 3500;
    localparam int RF_FALL_BASE_CYC = (RF_FALL_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int OFF_STEP_REF = 40;
    localparam int OFF_STEP_CYC = (OFF_STEP_REF * REF_PERIOD_PS + CLK_NS * 1000 - 1)
        / (CLK_NS * 1000);
    typedef enum logic [2:0]
    {
        TXS_STANDBY = 3'h0,
        TXS_IDLE = 3'h1,
        TXS_FSK = 3'h3,
        TXS_ASK_NORMAL = 3'h2,
        TXS_ASK_LOW = 3'h6
    } txs_mode_e;
    typedef enum logic [2:0]
    {
        ST_OFF = 3'h0,
        ST_WAKE = 3'h1,
        ST_READY = 3'h3,
        ST_ON = 3'h2,
        ST_DRAIN = 3'h6
    } txs_state_e;
endpackage

// ===== verilog/txs_core.sv
// serial configuration, mode control and tx framing of the transmitter
`timescale 1ns/1ps
module txs_core #(
    parameter int WARM_WAKE_LAG_CYC = txs_pkg::WARM_WAKE_LAG_US * 1000 / txs_pkg::CLK_NS,
    parameter int COLD_WAKE_CYC = txs_pkg::COLD_WAKE_US * 1000 / txs_pkg::CLK_NS,
    parameter int LOWCUR_WAKE_CYC = txs_pkg::LOWCUR_WAKE_US * 1000 / txs_pkg::CLK_NS
)
(
    // system
    input wire logic sys_clk,
    input wire logic rst,
    // serial bus, on its own clock
    input wire logic ser_clk,
    input wire logic ser_strobe,
    input wire logic ser_data,
    // discrete control pins
    input wire logic chip_on,
    input wire logic tx_on_n,
    input wire logic pll_locked,
    // baseband data
    input wire logic reference_clock,
    input wire logic tx_din,
    // handshake outputs
    output logic tx_valid,
    output logic tx_valid_n,
    // analog controls
    output logic rf_enable,
    output logic rf_data_valid,
    output logic mod_data,
    output logic pll_enable,
    output logic calibrating,
    output txs_pkg::txs_mode_e mode,
    // configuration fields
    output logic rate_select,
    output logic ask_select,
    output logic power_saving_select,
    output logic pll_sleep_select,
    output logic single_calibration,
    output logic lock_gate,
    output logic [7:0] divider_base,
    output logic filter_clock_edge,
    output logic filter_polarity,
    output logic [1:0] tx_off_delay,
    output logic [5:0] tx_on_delay,
    output logic [7:0] modulation_scale,
    output logic [7:0] modulation_scale_offset,
    output logic [2:0] integer_portion,
    output logic [19:0] fraction_portion
);

    ////////////////////////////////////////////////////////////////////////////
    // serial shift register, link clock domain

    logic [txs_pkg::WORD_W-1:0] shreg;

    // strobe high freezes the register so the other domain may read it
    always_ff @(posedge ser_clk or posedge rst)
    begin
        if (rst)
            shreg <= 24'h000000;
        else if (!ser_strobe)
            shreg <= {shreg[txs_pkg::WORD_W-2:0], ser_data}; // RULE6 RULE7
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: a change counts once stages two and three agree

    localparam int NPIN = 6;
    localparam int P_STB = 0;
    localparam int P_CE = 1;
    localparam int P_TXN = 2;
    localparam int P_LCK = 3;
    localparam int P_REF = 4;
    localparam int P_DIN = 5;

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1;
    logic [NPIN-1:0] sync2;
    logic [NPIN-1:0] sync3;
    logic [NPIN-1:0] pin;
    logic [NPIN-1:0] pin_d;
    logic [NPIN-1:0] next_pin;

    assign pin_raw = {tx_din, reference_clock, pll_locked, tx_on_n, chip_on, ser_strobe};
    assign next_pin = (sync2 & ~(sync2 ^ sync3)) | (pin & (sync2 ^ sync3));

    // tx_on_n idles high so the sync chain resets to one for it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1 <= 6'h05;
            sync2 <= 6'h05;
            sync3 <= 6'h05;
            pin <= 6'h05;
            pin_d <= 6'h05;
        end
        else
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pin <= next_pin;
            pin_d <= pin;
        end
    end

    wire strobe_rise = pin[P_STB] & ~pin_d[P_STB];
    wire ce = pin[P_CE];
    wire ce_rise = pin[P_CE] & ~pin_d[P_CE];
    wire txn = pin[P_TXN];
    wire locked = pin[P_LCK];
    wire ref_rise = pin[P_REF] & ~pin_d[P_REF];
    wire ref_fall = ~pin[P_REF] & pin_d[P_REF];

    ////////////////////////////////////////////////////////////////////////////
    // word decode on strobe rise

    localparam logic [txs_pkg::NUM_CFG*txs_pkg::CFG_W-1:0] CFG_RST_ALL = {
        txs_pkg::MODULATION_SCALE_CONFIG_RST,
        txs_pkg::RESERVED_CONFIG_THREE_RST,
        txs_pkg::TX_TIMING_CONFIG_RST,
        txs_pkg::FILTER_DIVIDER_CONFIG_RST,
        txs_pkg::MODE_CONFIG_RST
    };

    logic [txs_pkg::NUM_CFG-1:0][txs_pkg::CFG_W-1:0] cfg;
    logic [txs_pkg::NUM_CFG-1:0][txs_pkg::CFG_W-1:0] next_cfg;
    logic [txs_pkg::FREQ_W-1:0] freq;

    // shreg is stable while the strobe is high, so a word crossing is safe
    wire is_cfg = shreg[txs_pkg::TYPE_BIT]; // RULE10
    wire load_freq = strobe_rise & ~is_cfg; // RULE8 RULE12
    wire load_cfg = strobe_rise & is_cfg; // RULE8
    wire cfg_reset = load_cfg & shreg[txs_pkg::RESET_BIT]; // RULE15
    wire [4:0] cfg_addr = shreg[txs_pkg::ADDR_HI:txs_pkg::ADDR_LO];
    wire addr_ok = cfg_addr <= txs_pkg::MODULATION_SCALE_CONFIG_ADDR;
    wire cfg_write = load_cfg & shreg[txs_pkg::WGATE_BIT] & addr_ok; // RULE13 RULE25

    always_comb
    begin
        next_cfg = cfg_reset ? CFG_RST_ALL : cfg; // RULE15
        if (cfg_write)
            next_cfg[cfg_addr[2:0]] = shreg[txs_pkg::CFG_W-1:0]; // RULE13
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg <= CFG_RST_ALL;
            freq <= txs_pkg::FREQ_RST;
        end
        else
        begin
            cfg <= next_cfg;
            if (load_freq)
                freq <= shreg[txs_pkg::FREQ_W-1:0]; // RULE11
        end
    end

    wire [15:0] mode_word = cfg[txs_pkg::MODE_CONFIG_ADDR[2:0]];
    wire [15:0] filt_word = cfg[txs_pkg::FILTER_DIVIDER_CONFIG_ADDR[2:0]];
    wire [15:0] timing_word = cfg[txs_pkg::TX_TIMING_CONFIG_ADDR[2:0]];
    wire [15:0] scale_word = cfg[txs_pkg::MODULATION_SCALE_CONFIG_ADDR[2:0]];

    // RULE17
    assign rate_select = mode_word[txs_pkg::RATE_BIT];
    assign ask_select = mode_word[txs_pkg::ASK_BIT];
    assign power_saving_select = mode_word[txs_pkg::SAVE_BIT];
    assign pll_sleep_select = mode_word[txs_pkg::SLEEP_BIT];
    assign single_calibration = mode_word[txs_pkg::ONECAL_BIT];
    assign lock_gate = mode_word[txs_pkg::LOCKG_BIT];
    assign filter_clock_edge = filt_word[txs_pkg::FEDGE_BIT];
    assign filter_polarity = filt_word[txs_pkg::FPOL_BIT];
    assign tx_off_delay = timing_word[txs_pkg::OFFD_HI:txs_pkg::OFFD_LO];
    assign tx_on_delay = timing_word[txs_pkg::OND_HI:txs_pkg::OND_LO];
    assign modulation_scale = scale_word[txs_pkg::SCALE_HI:txs_pkg::SCALE_LO];
    assign modulation_scale_offset = scale_word[txs_pkg::SOFF_HI:txs_pkg::SOFF_LO];
    assign integer_portion = freq[txs_pkg::INT_HI:txs_pkg::INT_LO]; // RULE11
    assign fraction_portion = freq[txs_pkg::FRAC_HI:0]; // RULE11

    wire [7:0] next_divider_base =
        {4'h0, filt_word[txs_pkg::DIVOFF_HI:txs_pkg::DIVOFF_LO]} + txs_pkg::DIV_BASE_ADD; // RULE22

    ////////////////////////////////////////////////////////////////////////////
    // wake, transmit and turn-off sequencing

    localparam int TMR_W = 20;
    localparam int DV_W = 11;
    localparam logic [TMR_W-1:0] WARM_T = TMR_W'(WARM_WAKE_LAG_CYC - 1);
    localparam logic [TMR_W-1:0] COLD_T = TMR_W'(COLD_WAKE_CYC - 1);
    localparam logic [TMR_W-1:0] LOWC_T = TMR_W'(LOWCUR_WAKE_CYC - 1);
    localparam logic [TMR_W-1:0] OFF_BASE_T = TMR_W'(txs_pkg::RF_FALL_BASE_CYC - 1);
    localparam logic [TMR_W-1:0] OFF_STEP_T = TMR_W'(txs_pkg::OFF_STEP_CYC);
    localparam logic [DV_W-1:0] DV_T = DV_W'(txs_pkg::DATA_VALID_LAG_CYC - 1);

    txs_pkg::txs_state_e state;
    txs_pkg::txs_state_e next_state;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] next_tmr;
    logic [DV_W-1:0] dv_cnt;
    logic cal_done;
    logic cal_run;

    // the first chip-on after reset always calibrates
    wire need_cal = ~cal_done | (~single_calibration & ~txn); // RULE19
    wire [TMR_W-1:0] wake_t = ~need_cal ? WARM_T : // RULE3
        (power_saving_select ? LOWC_T : COLD_T);
    wire [TMR_W-1:0] off_t = OFF_BASE_T + TMR_W'(tx_off_delay) * OFF_STEP_T; // RULE21
    wire rf_go = ~txn & (locked | ~lock_gate); // RULE20 RULE1
    wire tmr_zero = tmr == 20'h00000;

    always_comb
    begin
        next_state = state;
        next_tmr = tmr_zero ? tmr : tmr - 20'h00001;
        unique case (state)
            txs_pkg::ST_OFF:
            begin
                if (ce_rise)
                begin
                    next_state = txs_pkg::ST_WAKE;
                    next_tmr = wake_t;
                end
            end
            txs_pkg::ST_WAKE:
            begin
                if (!ce)
                    next_state = txs_pkg::ST_OFF;
                else if (tmr_zero)
                    next_state = txs_pkg::ST_READY; // RULE3
            end
            txs_pkg::ST_READY:
            begin
                if (!ce)
                    next_state = txs_pkg::ST_OFF;
                else if (rf_go)
                    next_state = txs_pkg::ST_ON;
            end
            txs_pkg::ST_ON:
            begin
                if (!ce)
                    next_state = txs_pkg::ST_OFF;
                else if (!rf_go)
                begin
                    next_state = txs_pkg::ST_DRAIN;
                    next_tmr = off_t; // RULE4 RULE21
                end
            end
            txs_pkg::ST_DRAIN:
            begin
                if (!ce)
                    next_state = txs_pkg::ST_OFF;
                else if (rf_go)
                    next_state = txs_pkg::ST_ON;
                else if (tmr_zero)
                    next_state = txs_pkg::ST_READY; // RULE4
            end
            default:
                next_state = txs_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= txs_pkg::ST_OFF;
            tmr <= 20'h00000;
        end
        else
        begin
            state <= next_state;
            tmr <= next_tmr;
        end
    end

    // a reset word re-arms calibration; a finishing calibration wins over it
    wire cal_start = (state == txs_pkg::ST_OFF) && ce_rise && need_cal;
    wire cal_end = cal_run && (state == txs_pkg::ST_WAKE) && tmr_zero && ce;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cal_done <= 1'b0;
            cal_run <= 1'b0;
        end
        else
        begin
            if (cal_end)
                cal_done <= 1'b1;
            else if (cfg_reset)
                cal_done <= 1'b0; // RULE19
            if (cal_start)
                cal_run <= 1'b1;
            else if (state != txs_pkg::ST_WAKE || cal_end)
                cal_run <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output registers

    wire next_valid = (next_state == txs_pkg::ST_ON) && locked && ~txn; // RULE24
    wire next_rf = (next_state == txs_pkg::ST_ON) || (next_state == txs_pkg::ST_DRAIN);
    wire dv_hit = dv_cnt == DV_T;
    wire ref_edge = filter_clock_edge ? ref_fall : ref_rise;

    // modulation data follows the pin xor filter_polarity, timed by the reference clock
    wire next_mod = ref_edge ? (pin[P_DIN] ^ filter_polarity) : mod_data; // RULE5

    txs_pkg::txs_mode_e next_mode;
    assign next_mode = !ce ? txs_pkg::TXS_STANDBY : // RULE23
        txn ? txs_pkg::TXS_IDLE :
        !ask_select ? txs_pkg::TXS_FSK :
        power_saving_select ? txs_pkg::TXS_ASK_LOW : txs_pkg::TXS_ASK_NORMAL;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_valid <= 1'b0;
            tx_valid_n <= 1'b1;
            rf_enable <= 1'b0;
            dv_cnt <= 11'h000;
            rf_data_valid <= 1'b0;
            mod_data <= 1'b0;
            pll_enable <= 1'b0;
            calibrating <= 1'b0;
            mode <= txs_pkg::TXS_STANDBY;
            divider_base <= 8'h00;
        end
        else
        begin
            tx_valid <= next_valid; // RULE24
            tx_valid_n <= ~next_valid; // RULE24
            rf_enable <= next_rf; // RULE20
            if (!next_valid)
                dv_cnt <= 11'h000;
            else if (!dv_hit)
                dv_cnt <= dv_cnt + 11'h001;
            rf_data_valid <= next_valid && dv_hit; // RULE2
            mod_data <= next_mod;
            pll_enable <= ce && !(pll_sleep_select && txn); // RULE18
            calibrating <= cal_run;
            mode <= next_mode;
            divider_base <= next_divider_base;
        end
    end

endmodule // txs_core

// ===== verif/txs_core_assertions.sv
// concurrent property checker for the transmitter serial configuration block
`timescale 1ns/1ps
module txs_core_assertions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pins
    input wire logic ser_strobe,
    input wire logic chip_on,
    input wire logic tx_on_n,
    input wire logic pll_locked,
    // handshake and control outputs
    input wire logic tx_valid,
    input wire logic tx_valid_n,
    input wire logic rf_data_valid,
    input wire logic pll_enable,
    input wire txs_pkg::txs_mode_e mode,
    // configuration fields
    input wire logic ask_select,
    input wire logic power_saving_select,
    input wire logic pll_sleep_select,
    input wire logic [1:0] tx_off_delay,
    input wire logic [2:0] integer_portion,
    input wire logic [19:0] fraction_portion
);
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
////////////////////////////////////////
// cycles tx_valid has stood; the 7 us lag is too long for a repetition
int vcnt;
always_ff @(posedge sys_clk or posedge rst)
begin
    if (rst)
        vcnt <= 0;
    else
        vcnt <= tx_valid ? vcnt + 1 : 0;
end
////////////////////////////////////////
a_valid_pair: assert property (tx_valid_n == !tx_valid)
    else $error("tx_valid pair not complementary");
a_lock_drop: assert property ($fell(pll_locked) |-> ##[1:6] !tx_valid)
    else $error("tx_valid held after lock loss");
a_standby_mode: assert property (!chip_on [*6] |-> mode == txs_pkg::TXS_STANDBY)
    else $error("mode not standby with chip_on low");
a_txoff_valid: assert property (tx_on_n [*6] |-> !tx_valid)
    else $error("tx_valid high with tx_on_n high");
a_pll_sleep: assert property ((pll_sleep_select && tx_on_n) [*6] |-> !pll_enable)
    else $error("pll left on while asleep");
a_ask_low_mode: assert property (mode == txs_pkg::TXS_ASK_LOW |-> ask_select && power_saving_select)
    else $error("ask low mode without its fields");
a_data_early: assert property (rf_data_valid && tx_valid |-> vcnt >= txs_pkg::DATA_VALID_LAG_CYC - 1)
    else $error("data valid too early");
a_data_late: assert property (vcnt == txs_pkg::DATA_VALID_LAG_CYC + 3 && tx_valid |-> rf_data_valid)
    else $error("data valid too late");
a_hold_shift: assert property (!ser_strobe [*8] |=> $stable(integer_portion) && $stable(fraction_portion)
    && $stable(ask_select) && $stable(tx_off_delay))
    else $error("configuration changed while shifting");
c_tx_on: cover property ($rose(tx_valid));
c_ask_low: cover property (mode == txs_pkg::TXS_ASK_LOW);
c_lock_loss: cover property ($fell(pll_locked) && tx_valid);
endmodule // txs_core_assertions

// ===== verif/txs_host.sv
// host model driving the three-wire serial bus from its own clock
`timescale 1ns/1ps
module txs_host (
    // request from the bench
    input wire logic go,
    input wire logic [23:0] word,
    // serial bus
    output logic ser_clk,
    output logic ser_strobe,
    output logic ser_data,
    output logic busy
);
logic lclk = 1'b0;
logic gate = 1'b0;
////////////////////////////////////////
initial
begin
    #7;
    forever #40 lclk = ~lclk;
end
// clock stands still outside a frame; gate moves only while lclk is low
assign ser_clk = lclk & gate;
initial
begin
    ser_strobe = 1'b1;
    ser_data = 1'b0;
    busy = 1'b0;
    forever
    begin
        @(posedge go);
        busy = 1'b1;
        @(negedge lclk);
        ser_strobe = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            ser_data = word[i];
            gate = 1'b1;
            @(negedge lclk);
        end
        gate = 1'b0;
        ser_data = ~ser_data;
        #20 ser_strobe = 1'b1;
        repeat (26) @(negedge lclk);
        busy = 1'b0;
    end
end
endmodule // txs_host

// ===== verif/tx_serial_config_and_framing_bench.sv
// self-checking bench for the transmitter serial configuration block
`timescale 1ns/1ps
module tx_serial_config_and_framing_bench;
localparam int DFLT[5] = '{32'h263e, 32'h8487, 32'h158a, 32'h5505, 32'h0080};
localparam txs_pkg::txs_mode_e MODES[4] = '{txs_pkg::TXS_FSK, txs_pkg::TXS_FSK,
    txs_pkg::TXS_ASK_NORMAL, txs_pkg::TXS_ASK_LOW};
logic sys_clk, rst, chip_on, tx_on_n, pll_locked, go, ser_clk, ser_strobe, ser_data, busy;
logic reference_clock = 1'b0;
logic tx_din = 1'b0;
logic mod_on = 1'b0;
logic [23:0] word;
logic tx_valid, tx_valid_n, rf_enable, rf_data_valid, mod_data, pll_enable, calibrating;
logic rate_select, ask_select, power_saving_select, pll_sleep_select, single_calibration;
logic lock_gate, filter_clock_edge, filter_polarity;
logic [7:0] divider_base, modulation_scale, modulation_scale_offset;
logic [1:0] tx_off_delay;
logic [5:0] tx_on_delay;
logic [2:0] integer_portion;
logic [19:0] fraction_portion;
logic [63:0] fields;
txs_pkg::txs_mode_e mode;
int n_fail, checks, n, rcnt, freq, lo;
int cfg[5];
logic [31:0] rnd;
logic [31:0] dr = 32'h9d72ce39;
assign fields = {1'b0, rate_select, ask_select, power_saving_select, pll_sleep_select,
    single_calibration, lock_gate, divider_base, filter_clock_edge, filter_polarity, tx_off_delay,
    tx_on_delay, modulation_scale, modulation_scale_offset, integer_portion, fraction_portion};
txs_core #(.WARM_WAKE_LAG_CYC(20), .COLD_WAKE_CYC(40), .LOWCUR_WAKE_CYC(60)) i_dut (.sys_clk,
    .rst, .ser_clk, .ser_strobe, .ser_data, .chip_on, .tx_on_n, .pll_locked, .reference_clock,
    .tx_din, .tx_valid, .tx_valid_n, .rf_enable, .rf_data_valid, .mod_data, .pll_enable,
    .calibrating, .mode, .rate_select, .ask_select, .power_saving_select, .pll_sleep_select,
    .single_calibration, .lock_gate, .divider_base, .filter_clock_edge, .filter_polarity,
    .tx_off_delay, .tx_on_delay, .modulation_scale, .modulation_scale_offset, .integer_portion,
    .fraction_portion);
txs_host i_host (.go, .word, .ser_clk, .ser_strobe, .ser_data, .busy);
////////////////////////////////////////
function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
// divider base is the offset plus 147
function automatic logic [63:0] exp_fields();
    return {1'b0, cfg[0][14:9], 8'(cfg[1][15:12] + 8'h93), cfg[1][5:4], cfg[2][7:0],
        cfg[4][15:0], freq[22:0]};
endfunction
task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
        n_fail++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic results();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
// n counts falling edges until the selected signal reaches v
task automatic wait_on(input int sel, input logic v, input int lim);
    logic s;
    n = 0;
    s = ~v;
    while (s !== v)
    begin
        @(negedge sys_clk);
        n++;
        s = (sel == 0) ? tx_valid : (sel == 1) ? rf_data_valid : (sel == 2) ? rf_enable : busy;
        if (n > lim)
        begin
            n_fail++;
            $display("[ERR] %0t wait %h stuck want %h", $time, sel, v);
            results();
        end
    end
endtask
task automatic send(input logic [23:0] w);
    word = w;
    go = 1'b1;
    wait_on(3, 1'b1, 100);
    go = 1'b0;
    wait_on(3, 1'b0, 2000);
    if (!w[23])
        freq = int'(w[22:0]);
    else
    begin
        if (w[22])
            cfg = DFLT;
        if (w[21] && w[20:16] < 5)
            cfg[w[20:16]] = int'(w[15:0]);
    end
    chk(fields, exp_fields());
endtask
////////////////////////////////////////
initial
begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
end
// reference as a data pin; din moves on the edge that does not capture it
always @(negedge sys_clk)
begin
    rcnt <= (rcnt == 9) ? 0 : rcnt + 1;
    if (rcnt == 9)
    begin
        reference_clock <= ~reference_clock;
        if ((~reference_clock) == cfg[1][5])
        begin
            if (mod_on)
                chk(64'(mod_data), 64'(tx_din ^ cfg[1][4]));
            dr <= lfsr(dr);
            tx_din <= dr[0];
        end
    end
end
initial
begin
    rst = 1'b1;
    chip_on = 1'b0;
    tx_on_n = 1'b1;
    pll_locked = 1'b1;
    go = 1'b0;
    word = 24'h000000;
    cfg = DFLT;
    freq = 0;
    rnd = 32'h9d72ce39;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(fields, exp_fields());
    send(24'hc00000);
    send(24'ha0263e);
    for (int i = 0; i < 21; i++)
    begin
        rnd = lfsr(rnd);
        if (i % 3 == 0)
            send({1'b0, rnd[22:0]});
        else
            send({1'b1, 1'(i == 20), 1'(i % 4 != 1), 5'(i % 7), rnd[15:0]});
    end
    send(24'ha184b7);
    mod_on = 1'b1;
    repeat (200) @(negedge sys_clk);
    mod_on = 1'b0;
    $display("configuration and data path test done");
    for (int d = 0; d < 4; d++)
    begin
        if (d == 1)
            send(24'hc00000);
        send({8'ha2, 16'h1500 | 16'(d * 64 + 10)});
        send({8'ha0, 16'h063e | 16'(d << 12)});
        chip_on = 1'b1;
        tx_on_n = 1'b0;
        lo = (d == 0) ? 40 : (d == 1) ? 60 : 20;
        repeat (10) @(negedge sys_clk);
        chk(64'(calibrating), 64'(d < 2));
        wait_on(0, 1'b1, 200);
        chk(64'(n + 10 >= lo && n + 10 <= lo + 12), 64'h1);
        chk(64'({mode, tx_valid_n}), 64'({MODES[d], 1'b0}));
        wait_on(1, 1'b1, 2000);
        chk(64'(n >= 1748 && n <= 1752), 64'h1);
        if (d == 2)
            send({1'b0, rnd[22:0] ^ 23'h05a5a5});
        tx_on_n = 1'b1;
        wait_on(0, 1'b0, 20);
        wait_on(2, 1'b0, 4000);
        chk(64'(n + 3 >= 875 + d * 814 && n <= 878 + d * 814), 64'h1);
        chip_on = 1'b0;
        repeat (8) @(negedge sys_clk);
        $display("transmit pass %0d done", d);
    end
    send(24'ha02e3e);
    chip_on = 1'b1;
    repeat (40) @(negedge sys_clk);
    chk(64'(pll_enable), 64'h0);
    tx_on_n = 1'b0;
    wait_on(0, 1'b1, 200);
    chk(64'(pll_enable), 64'h1);
    pll_locked = 1'b0;
    wait_on(0, 1'b0, 10);
    chk(64'(tx_valid_n), 64'h1);
    $display("lock loss test done");
    results();
end
endmodule // tx_serial_config_and_framing_bench
bind txs_core txs_core_assertions i_chk (.sys_clk, .rst, .ser_strobe, .chip_on, .tx_on_n,
    .pll_locked, .tx_valid, .tx_valid_n, .rf_data_valid, .pll_enable, .mode, .ask_select,
    .power_saving_select, .pll_sleep_select, .tx_off_delay, .integer_portion, .fraction_portion);
